// ==== pef_defs.svh ====
`ifndef PEF_DEFS_SVH
`define PEF_DEFS_SVH

// Data widths of the playback path.
`define PEF_SAMPLE_W 16
`define PEF_COEF_W 16
`define PEF_WIDE_W 40
`define PEF_NUM_CH 2

// Coefficient store layout, thirteen words per channel.
`define PEF_COEF_PER_CH 13
`define PEF_COEF_NUM 26
`define PEF_IDX_DE_BASE 0
`define PEF_IDX_B1_BASE 3
`define PEF_IDX_B2_BASE 8

// Reset coefficient values, 48 kHz de-emphasis and the shelving biquad.
`define PEF_RST_DE_LEAD 16'h3955
`define PEF_RST_DE_D1NUM 16'hF32D
`define PEF_RST_DE_D1FB 16'h537E
`define PEF_RST_BQ_LEAD 16'h6BE3
`define PEF_RST_BQ_D1NUM 16'h9666
`define PEF_RST_BQ_D2NUM 16'h675D
`define PEF_RST_BQ_D1FB 16'h7D83
`define PEF_RST_BQ_D2FB 16'h84EE

// Fixed point scaling: 32768 is a shift by fifteen.
`define PEF_FRAC_SHIFT 15
`define PEF_ATTEN_SHIFT 4
`define PEF_GAIN_SHIFT 6
`define PEF_GAIN_MAX 7'h40

// Oversampled modulator rate and its fractional divider.
`define PEF_SYS_CLK_HZ 10000000
`define PEF_REFERENCE_SAMPLE_RATE_HZ 48000
`define PEF_OSR_FIXED 128
`define PEF_ACC_W 24
`define PEF_INTERP_SHIFT 3
`define PEF_DSM_W 5
`define PEF_DSM_SHIFT 12
`define PEF_ERR_W 18

`endif

// ==== pef_pkg.sv ====
package pef_pkg;
`include "pef_defs.svh"

	// Sequencer states, one-hot.
	typedef enum logic [4:0] {
		PEF_IDLE = 5'h01,
		PEF_DE = 5'h02,
		PEF_B1 = 5'h04,
		PEF_B2 = 5'h08,
		PEF_MIX = 5'h10
	} pef_fsm_t;

	// Processing configuration that is switched under soft mute.
	typedef struct packed {
		logic three_d;
		logic effects;
		logic deemph;
	} pef_cfg_t;

	// Complete state of the filter chain.
	typedef struct packed {
		pef_fsm_t fsm;
		logic ch;
		logic [`PEF_COEF_NUM-1:0][`PEF_COEF_W-1:0] shadow;
		logic [`PEF_COEF_NUM-1:0][`PEF_COEF_W-1:0] active;
		logic [`PEF_NUM_CH-1:0][`PEF_SAMPLE_W-1:0] inp;
		logic [`PEF_NUM_CH-1:0][`PEF_SAMPLE_W-1:0] work;
		logic [`PEF_NUM_CH-1:0][`PEF_SAMPLE_W-1:0] mid;
		logic [`PEF_NUM_CH-1:0][`PEF_SAMPLE_W-1:0] eff;
		logic [`PEF_NUM_CH-1:0][`PEF_SAMPLE_W-1:0] held;
		logic [`PEF_NUM_CH-1:0][`PEF_SAMPLE_W-1:0] interp;
		logic [`PEF_NUM_CH-1:0][2:0][3:0][`PEF_SAMPLE_W-1:0] hist;
		pef_cfg_t applied;
		logic [6:0] gain;
		logic proc_valid;
		logic [`PEF_ACC_W-1:0] phase;
		logic dsm_tick;
		logic [`PEF_NUM_CH-1:0][`PEF_ERR_W-1:0] err;
		logic [`PEF_NUM_CH-1:0][`PEF_DSM_W-1:0] dsm;
	} pef_chain_t;

	// Clamp a wide result to the sample range instead of wrapping.
	function automatic logic [`PEF_SAMPLE_W-1:0] pef_sat16(input logic signed [39:0] v);
		if (v > 40'sh0000007FFF) begin
			return 16'h7FFF;
		end else if (v < -40'sh0000008000) begin
			return 16'h8000;
		end
		return v[15:0];
	endfunction : pef_sat16

endpackage : pef_pkg

// ==== pef_sec_if.sv ====
`timescale 1ns/1ns
`include "pef_defs.svh"
// Operands and result of the shared filter section.
interface pef_sec_if;
	import pef_pkg::*;
	logic first_order;
	logic [`PEF_SAMPLE_W-1:0] x;
	logic [`PEF_SAMPLE_W-1:0] x1;
	logic [`PEF_SAMPLE_W-1:0] x2;
	logic [`PEF_SAMPLE_W-1:0] y1;
	logic [`PEF_SAMPLE_W-1:0] y2;
	logic [4:0][`PEF_COEF_W-1:0] c;
	logic [`PEF_SAMPLE_W-1:0] y;
	modport ctrl (output first_order, x, x1, x2, y1, y2, c, input y);
	modport unit (input first_order, x, x1, x2, y1, y2, c, output y);
endinterface : pef_sec_if

// ==== pef_section.sv ====
`timescale 1ns/1ns
`include "pef_defs.svh"
// One filter section, used in turn for de-emphasis and both biquads.
module pef_section
	import pef_pkg::*;
(
	// Operands in, result out.
	pef_sec_if.unit s
);

	logic signed [39:0] acc;
	logic signed [39:0] t_d1num;
	logic signed [39:0] t_d1fb;

	// Coefficient order in c: lead, delay1 num, delay2 num, delay1 fb, delay2 fb.
	always_comb begin
		t_d1num = 40'(signed'(s.c[1])) * 40'(signed'(s.x1));
		t_d1fb = 40'(signed'(s.c[3])) * 40'(signed'(s.y1));
		acc = 40'(signed'(s.c[0])) * 40'(signed'(s.x));
		if (s.first_order) begin
			acc = acc + t_d1num + t_d1fb;
		end else begin
			// Biquad doubles the delay1 terms and adds the delay2 terms.
			acc = acc + (t_d1num <<< 1) + (t_d1fb <<< 1)
				+ 40'(signed'(s.c[2])) * 40'(signed'(s.x2))
				+ 40'(signed'(s.c[4])) * 40'(signed'(s.y2));
		end
	end

	// Dividing by the shift keeps rounding toward minus infinity, small bias accepted.
	assign s.y = pef_sat16(acc >>> `PEF_FRAC_SHIFT);

endmodule : pef_section

// ==== pef_filter_chain.sv ====
`timescale 1ns/1ns
`include "pef_defs.svh"
// Functional notes
// - Each channel goes processing, then interpolation, then multi-bit modulator.
// - Samples are taken on a strobe, any rate from 8 to 96 kHz.
// - Modulator runs at a fixed 128 times the reference rate.
// - De-emphasis is a first-order IIR with a 32768 denominator.
// - Three de-emphasis coefficients per channel, each writable alone.
// - De-emphasis coefficients reset to the 48 kHz set.
// - The first-order section accepts any coefficients as a general filter.
// - Fourth-order IIR per channel from two cascaded biquads with own coefficients.
// - Biquad uses doubled delay1 terms and delay2 terms over 32768.
// - The whole fourth-order filter is enabled or bypassed unchanged.
// - Coefficients are 16-bit two's complement.
// - Both biquad sections reset to the same shelving coefficients.
// - 3-D mode filters the mono mix and adds it to each channel.
// - A programmable attenuation scales the mono contribution in 3-D mode.
// - Switching processing soft-mutes, changes the setting, then soft-unmutes.
module pef_filter_chain
	import pef_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Playback samples from the serial data interface.
	input wire logic sample_valid_i,
	output logic sample_ready_o,
	input wire logic [`PEF_SAMPLE_W-1:0] sample_left_i,
	input wire logic [`PEF_SAMPLE_W-1:0] sample_right_i,
	// Coefficient write port.
	input wire logic coef_wr_i,
	input wire logic [4:0] coef_idx_i,
	input wire logic [`PEF_COEF_W-1:0] coef_data_i,
	// Processing controls.
	input wire logic deemph_en_i,
	input wire logic effects_en_i,
	input wire logic three_d_en_i,
	input wire logic [3:0] three_d_atten_i,
	// Processed samples at the input rate.
	output logic proc_valid_o,
	output logic [`PEF_SAMPLE_W-1:0] proc_left_o,
	output logic [`PEF_SAMPLE_W-1:0] proc_right_o,
	output logic soft_mute_busy_o,
	// Oversampled modulator output.
	output logic dsm_tick_o,
	output logic [`PEF_DSM_W-1:0] dsm_left_o,
	output logic [`PEF_DSM_W-1:0] dsm_right_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Constants.

	localparam logic [63:0] PHASE_INC64 = ((64'(`PEF_OSR_FIXED) * 64'(`PEF_REFERENCE_SAMPLE_RATE_HZ))
		<< `PEF_ACC_W) / 64'(`PEF_SYS_CLK_HZ);
	localparam logic [`PEF_ACC_W-1:0] PHASE_INC = PHASE_INC64[`PEF_ACC_W-1:0];

	// Reset value of a coefficient word by its position in the store.
	function automatic logic [`PEF_COEF_W-1:0] coef_default(input int k);
		case (k % `PEF_COEF_PER_CH)
			0: return `PEF_RST_DE_LEAD;
			1: return `PEF_RST_DE_D1NUM;
			2: return `PEF_RST_DE_D1FB;
			3, 8: return `PEF_RST_BQ_LEAD;
			4, 9: return `PEF_RST_BQ_D1NUM;
			5, 10: return `PEF_RST_BQ_D2NUM;
			6, 11: return `PEF_RST_BQ_D1FB;
			7, 12: return `PEF_RST_BQ_D2FB;
			default: return 16'h0000;
		endcase
	endfunction : coef_default

	function automatic pef_chain_t reset_chain();
		pef_chain_t r;
		r = '0;
		r.fsm = PEF_IDLE;
		for (int i = 0; i < `PEF_COEF_NUM; i++) begin
			r.shadow[i] = coef_default(i);
			r.active[i] = coef_default(i);
		end
		return r;
	endfunction : reset_chain

	localparam pef_chain_t RESET_CHAIN = reset_chain();

	// Start of a section's coefficients for a channel.
	function automatic logic [4:0] coef_base(input logic ch, input logic [1:0] sec);
		logic [4:0] b;
		b = ch ? 5'(`PEF_COEF_PER_CH) : 5'h00;
		case (sec)
			2'd1: b = b + 5'(`PEF_IDX_B1_BASE);
			2'd2: b = b + 5'(`PEF_IDX_B2_BASE);
			default: b = b + 5'(`PEF_IDX_DE_BASE);
		endcase
		return b;
	endfunction : coef_base

	////////////////////////////////////////////////////////////////////////////////
	// Reset release.

	logic rst_meta_n;
	logic rst_sync_n;

	// The release is synchronised so no state leaves reset on a partial edge.
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_n <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_sync_n <= rst_meta_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Shared section and its operand select.

	pef_chain_t cur;
	pef_chain_t next_chain;
	pef_sec_if sec ();
	logic [1:0] sec_sel;
	logic [4:0] base;
	logic [`PEF_SAMPLE_W-1:0] mono;

	pef_section u_section (
		.s(sec)
	);

	// Mono mix of the de-emphasised channels, halved to stay in range.
	assign mono = pef_sat16((40'(signed'(cur.work[0])) + 40'(signed'(cur.work[1]))) >>> 1);

	// The state picks which channel and section the shared arithmetic serves.
	always_comb begin
		case (cur.fsm)
			PEF_B1: sec_sel = 2'd1;
			PEF_B2: sec_sel = 2'd2;
			default: sec_sel = 2'd0;
		endcase
		base = coef_base(cur.ch, sec_sel);
		sec.first_order = (cur.fsm == PEF_DE);
		sec.c[0] = cur.active[base];
		sec.c[1] = cur.active[5'(base + 5'h01)];
		if (cur.fsm == PEF_DE) begin
			sec.c[2] = 16'h0000;
			sec.c[3] = cur.active[5'(base + 5'h02)];
			sec.c[4] = 16'h0000;
		end else begin
			sec.c[2] = cur.active[5'(base + 5'h02)];
			sec.c[3] = cur.active[5'(base + 5'h03)];
			sec.c[4] = cur.active[5'(base + 5'h04)];
		end
		case (cur.fsm)
			PEF_B1: sec.x = cur.applied.three_d ? mono : cur.work[cur.ch];
			PEF_B2: sec.x = cur.mid[cur.ch];
			default: sec.x = cur.inp[cur.ch];
		endcase
		sec.x1 = cur.hist[cur.ch][sec_sel][0];
		sec.x2 = cur.hist[cur.ch][sec_sel][1];
		sec.y1 = cur.hist[cur.ch][sec_sel][2];
		sec.y2 = cur.hist[cur.ch][sec_sel][3];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	pef_cfg_t req;
	logic signed [39:0] mixv;
	logic [`PEF_SAMPLE_W-1:0] mixs;
	logic signed [39:0] dif;
	logic signed [39:0] dsum;
	logic signed [39:0] q;
	logic [`PEF_DSM_W-1:0] qs;
	logic [`PEF_ACC_W:0] phase_sum;

	assign req = '{three_d: three_d_en_i, effects: effects_en_i, deemph: deemph_en_i};

	// Sequencer, coefficient store, soft mute, interpolator and modulator.
	always_comb begin
		next_chain = cur;
		next_chain.proc_valid = 1'b0;
		mixv = '0;
		mixs = '0;
		dif = '0;
		dsum = '0;
		q = '0;
		qs = '0;
		// Writes land in the shadow bank; the filters never see them mid-sample.
		if (coef_wr_i && (coef_idx_i < 5'(`PEF_COEF_NUM))) begin
			next_chain.shadow[coef_idx_i] = coef_data_i;
		end
		case (cur.fsm)
			PEF_IDLE: begin
				if (sample_valid_i) begin
					next_chain.inp[0] = sample_left_i;
					next_chain.inp[1] = sample_right_i;
					next_chain.active = cur.shadow;
					next_chain.ch = 1'b0;
					next_chain.fsm = PEF_DE;
				end
			end
			PEF_DE: begin
				if (cur.applied.deemph) begin
					next_chain.work[cur.ch] = sec.y;
					next_chain.hist[cur.ch][0] = {16'h0000, sec.y, 16'h0000, sec.x};
				end else begin
					next_chain.work[cur.ch] = sec.x;
				end
				next_chain.ch = ~cur.ch;
				next_chain.fsm = cur.ch ? PEF_B1 : PEF_DE;
			end
			PEF_B1, PEF_B2: begin
				if (cur.applied.effects) begin
					next_chain.hist[cur.ch][sec_sel] = {sec.y1, sec.y, sec.x1, sec.x};
				end
				if (cur.fsm == PEF_B1) begin
					next_chain.mid[cur.ch] = cur.applied.effects ? sec.y : sec.x;
					next_chain.fsm = PEF_B2;
				end else begin
					next_chain.eff[cur.ch] = cur.applied.effects ? sec.y : sec.x;
					if (!cur.ch && !cur.applied.three_d) begin
						next_chain.ch = 1'b1;
						next_chain.fsm = PEF_B1;
					end else begin
						next_chain.ch = 1'b0;
						next_chain.fsm = PEF_MIX;
					end
				end
			end
			PEF_MIX: begin
				for (int c = 0; c < `PEF_NUM_CH; c++) begin
					if (cur.applied.three_d) begin
						mixv = 40'(signed'(cur.work[c])) + ((40'(signed'(cur.eff[0]))
							* 40'(signed'({1'b0, three_d_atten_i}))) >>> `PEF_ATTEN_SHIFT);
					end else begin
						mixv = 40'(signed'(cur.eff[c]));
					end
					mixs = pef_sat16(mixv);
					next_chain.held[c] = pef_sat16((40'(signed'(mixs))
						* 40'(signed'({1'b0, cur.gain}))) >>> `PEF_GAIN_SHIFT);
				end
				// Change processing only once fully muted, then ramp back up.
				if (req != cur.applied) begin
					if (cur.gain != 7'h00) begin
						next_chain.gain = cur.gain - 7'h01;
					end else begin
						next_chain.applied = req;
					end
				end else if (cur.gain != `PEF_GAIN_MAX) begin
					next_chain.gain = cur.gain + 7'h01;
				end
				next_chain.proc_valid = 1'b1;
				next_chain.fsm = PEF_IDLE;
			end
			default: next_chain.fsm = PEF_IDLE;
		endcase
		// Fractional divider keeps the modulator rate fixed for any input rate.
		phase_sum = {1'b0, cur.phase} + {1'b0, PHASE_INC};
		next_chain.phase = phase_sum[`PEF_ACC_W-1:0];
		next_chain.dsm_tick = phase_sum[`PEF_ACC_W];
		if (phase_sum[`PEF_ACC_W]) begin
			for (int c = 0; c < `PEF_NUM_CH; c++) begin
				// One-pole interpolator smooths the held sample toward the new one.
				dif = 40'(signed'(cur.held[c])) - 40'(signed'(cur.interp[c]));
				next_chain.interp[c] = 16'(40'(signed'(cur.interp[c]))
					+ (dif >>> `PEF_INTERP_SHIFT));
				// Error feedback quantiser; five bits cover the full sample range.
				dsum = 40'(signed'(cur.interp[c])) + 40'(signed'(cur.err[c]));
				q = dsum >>> `PEF_DSM_SHIFT;
				qs = q[`PEF_DSM_W-1:0];
				next_chain.dsm[c] = qs;
				next_chain.err[c] = 18'(dsum - (40'(signed'(qs)) <<< `PEF_DSM_SHIFT));
			end
		end
	end

	// Single register for the whole state.
	always_ff @(posedge sys_clk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cur <= RESET_CHAIN;
		end else begin
			cur <= next_chain;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign sample_ready_o = (cur.fsm == PEF_IDLE);
	assign proc_valid_o = cur.proc_valid;
	assign proc_left_o = cur.held[0];
	assign proc_right_o = cur.held[1];
	assign soft_mute_busy_o = (cur.gain != `PEF_GAIN_MAX) || (req != cur.applied);
	assign dsm_tick_o = cur.dsm_tick;
	assign dsm_left_o = cur.dsm[0];
	assign dsm_right_o = cur.dsm[1];

endmodule : pef_filter_chain

// ==== pef_src_model.sv ====
`timescale 1ns/1ns
`include "pef_defs.svh"
// Serial data side: offers one stereo pair and holds it until the chain takes it.
module pef_src_model (
	// Clock and handshake.
	input wire logic sys_clk_i,
	input wire logic sample_ready_i,
	// Offered pair.
	output logic sample_valid_o,
	output logic [`PEF_SAMPLE_W-1:0] sample_left_o,
	output logic [`PEF_SAMPLE_W-1:0] sample_right_o
);
	// Cycles between offers: 105 is just under 96 kHz, 1250 is 8 kHz.
	int gap = 105;
	// Idle lines carry a pattern, never a settled unknown.
	initial begin
		sample_valid_o = 1'b0;
		sample_left_o = 16'h5A5A;
		sample_right_o = 16'hA5A5;
	end
	// Ready is read once it has settled, so acceptance is the following edge.
	// Released lines flip to the inverse, so stale data never passes as fresh.
	task automatic send(input logic [15:0] l, input logic [15:0] r);
		repeat (gap) @(posedge sys_clk_i);
		#10;
		sample_valid_o = 1'b1;
		sample_left_o = l;
		sample_right_o = r;
		while (sample_ready_i !== 1'b1) begin
			@(posedge sys_clk_i);
			#10;
		end
		@(posedge sys_clk_i);
		#10;
		sample_valid_o = 1'b0;
		sample_left_o = ~l;
		sample_right_o = ~r;
	endtask : send
endmodule : pef_src_model

// ==== pef_filter_chain_chk.sv ====
`timescale 1ns/1ns
`include "pef_defs.svh"
// Port-level timing checks of the filter chain.
module pef_filter_chain_chk (
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	// Handshake and controls.
	input wire logic sample_valid_i,
	input wire logic sample_ready_o,
	input wire logic deemph_en_i,
	input wire logic effects_en_i,
	input wire logic three_d_en_i,
	// Outputs.
	input wire logic proc_valid_o,
	input wire logic [`PEF_SAMPLE_W-1:0] proc_left_o,
	input wire logic [`PEF_SAMPLE_W-1:0] proc_right_o,
	input wire logic soft_mute_busy_o,
	input wire logic dsm_tick_o,
	input wire logic [`PEF_DSM_W-1:0] dsm_left_o,
	input wire logic [`PEF_DSM_W-1:0] dsm_right_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	// The internal reset lags the pin by two edges, so tick spacing waits a few edges.
	logic [2:0] up;
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			up <= 3'h0;
		end else if (up != 3'h7) begin
			up <= up + 3'h1;
		end
	end
	wire logic take = sample_valid_i && sample_ready_o;
	////////////////////////////////////////////////////////////
	AST_TAKE_BUSY: assert property (take |=>
		(!sample_ready_o && !proc_valid_o) [*5] ##[1:3] proc_valid_o)
		else $error("processed pair late or ready not dropped");
	AST_READY_BACK: assert property (proc_valid_o |-> sample_ready_o)
		else $error("ready low with a new pair");
	AST_PV_PULSE: assert property (proc_valid_o |=> !proc_valid_o)
		else $error("processed valid longer than one cycle");
	AST_OUT_HOLD: assert property (!proc_valid_o |-> $stable(proc_left_o) && $stable(proc_right_o))
		else $error("processed data changed without valid");
	AST_DSM_GAP: assert property (up == 3'h7 && !dsm_tick_o |=> dsm_tick_o)
		else $error("modulator tick gap too long");
	AST_DSM_HOLD: assert property (!dsm_tick_o |-> $stable(dsm_left_o) && $stable(dsm_right_o))
		else $error("modulator code changed without tick");
	AST_BUSY_SW: assert property ($changed({deemph_en_i, effects_en_i, three_d_en_i}) |->
		soft_mute_busy_o)
		else $error("control change without soft mute");
	AST_BUSY_END: assert property ($fell(soft_mute_busy_o) |-> proc_valid_o)
		else $error("soft mute ended off a sample");
	// Main scenarios.
	cover property (take && three_d_en_i);
	cover property ($fell(soft_mute_busy_o));
	cover property (proc_valid_o && effects_en_i);
endmodule : pef_filter_chain_chk
bind pef_filter_chain pef_filter_chain_chk chk_u (
	.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .sample_valid_i(sample_valid_i),
	.sample_ready_o(sample_ready_o), .deemph_en_i(deemph_en_i), .effects_en_i(effects_en_i),
	.three_d_en_i(three_d_en_i), .proc_valid_o(proc_valid_o), .proc_left_o(proc_left_o),
	.proc_right_o(proc_right_o), .soft_mute_busy_o(soft_mute_busy_o), .dsm_tick_o(dsm_tick_o),
	.dsm_left_o(dsm_left_o), .dsm_right_o(dsm_right_o)
);

// ==== pef_filter_chain_tb.sv ====
`timescale 1ns/1ns
`include "pef_defs.svh"
// Compare and count; an unknown never matches.
`define PEF_CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin \
	miscompares++; $display("BAD %s exp %h got %h", nm, exp, got); end end
module pef_filter_chain_tb;
	import pef_pkg::*;
	logic sys_clk_i, rst_n_i, sample_valid_i, sample_ready_o, coef_wr_i;
	logic deemph_en_i, effects_en_i, three_d_en_i, proc_valid_o, soft_mute_busy_o, dsm_tick_o;
	logic [4:0] coef_idx_i, dsm_left_o, dsm_right_o;
	logic [3:0] three_d_atten_i;
	logic [15:0] sample_left_i, sample_right_i, coef_data_i, proc_left_o, proc_right_o, ol, orr;
	int miscompares = 0;
	int total_checks = 0;
	int cyc = 0;
	int n = 0;
	pef_filter_chain dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.sample_valid_i(sample_valid_i), .sample_ready_o(sample_ready_o),
		.sample_left_i(sample_left_i), .sample_right_i(sample_right_i), .coef_wr_i(coef_wr_i),
		.coef_idx_i(coef_idx_i), .coef_data_i(coef_data_i), .deemph_en_i(deemph_en_i),
		.effects_en_i(effects_en_i), .three_d_en_i(three_d_en_i),
		.three_d_atten_i(three_d_atten_i), .proc_valid_o(proc_valid_o),
		.proc_left_o(proc_left_o), .proc_right_o(proc_right_o),
		.soft_mute_busy_o(soft_mute_busy_o), .dsm_tick_o(dsm_tick_o),
		.dsm_left_o(dsm_left_o), .dsm_right_o(dsm_right_o));
	pef_src_model src_u (.sys_clk_i(sys_clk_i), .sample_ready_i(sample_ready_o),
		.sample_valid_o(sample_valid_i), .sample_left_o(sample_left_i),
		.sample_right_o(sample_right_i));
	////////////////////////////////////////////////////////////
	// One fixed 10 MHz clock; no divide ratio is programmed, so none outside the allowed set.
	initial begin
		sys_clk_i = 1'b0;
		forever #50 sys_clk_i = ~sys_clk_i;
	end
	// A hang ends the run as a mismatch.
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 95000) begin
			miscompares++;
			test_done();
		end
	end
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done
	task automatic cfg(input logic d, input logic e, input logic t);
		deemph_en_i = d;
		effects_en_i = e;
		three_d_en_i = t;
	endtask : cfg
	task automatic wr(input logic [4:0] i, input logic [15:0] d);
		@(posedge sys_clk_i);
		#10;
		coef_wr_i = 1'b1;
		coef_idx_i = i;
		coef_data_i = d;
		@(posedge sys_clk_i);
		#10;
		coef_wr_i = 1'b0;
	endtask : wr
	// One pair through the chain; the result pulse lasts one cycle.
	task automatic xfer(input logic [15:0] l, input logic [15:0] r);
		int k;
		k = 0;
		src_u.send(l, r);
		while (proc_valid_o !== 1'b1 && k < 20) begin
			@(posedge sys_clk_i);
			#10;
			k++;
		end
		`PEF_CHK("proc_valid", 1'b1, proc_valid_o)
		ol = proc_left_o;
		orr = proc_right_o;
	endtask : xfer
	// Feed a steady pair until the mute ramp is over, then one more at full gain.
	task automatic settle(input logic [15:0] l, input logic [15:0] r);
		int k;
		k = 0;
		do begin
			xfer(l, r);
			k++;
		end while (soft_mute_busy_o !== 1'b0 && k < 200);
		`PEF_CHK("mute_done", 1'b0, soft_mute_busy_o)
		xfer(l, r);
	endtask : settle
	////////////////////////////////////////////////////////////
	initial begin
		rst_n_i = 1'b0;
		coef_wr_i = 1'b0;
		coef_idx_i = 5'h00;
		coef_data_i = 16'h0000;
		three_d_atten_i = 4'h8;
		cfg(1'b1, 1'b0, 1'b0);
		repeat (12) @(posedge sys_clk_i);
		#10;
		rst_n_i = 1'b1;
		// The internal reset lags by two edges; count only edges that advance the phase.
		repeat (2) @(posedge sys_clk_i);
		repeat (5000) begin
			@(posedge sys_clk_i);
			#10;
			n += dsm_tick_o;
		end
		`PEF_CHK("dsm_rate", 1'b1, (n >= 3071 && n <= 3073))
		// Impulse through the default first-order set, both channels.
		settle(16'h0000, 16'h0000);
		xfer(16'h4000, 16'hC000);
		`PEF_CHK("de_l0", 16'h1CAA, ol)
		`PEF_CHK("de_r0", 16'hE355, orr)
		xfer(16'h0000, 16'h0000);
		`PEF_CHK("de_l1", 16'h0C48, ol)
		`PEF_CHK("de_r1", 16'hF3B6, orr)
		cfg(1'b0, 1'b0, 1'b0);
		settle(16'h1234, 16'h8765);
		`PEF_CHK("byp_l", 16'h1234, ol)
		`PEF_CHK("byp_r", 16'h8765, orr)
		// General use of the first-order block; index 26 must be ignored.
		wr(5'd0, 16'h7FFF);
		wr(5'd1, 16'h7FFF);
		wr(5'd2, 16'h0000);
		wr(5'd13, 16'h7FFF);
		wr(5'd14, 16'h0000);
		wr(5'd15, 16'h0000);
		wr(5'd26, 16'h0000);
		cfg(1'b1, 1'b0, 1'b0);
		settle(16'h7FFF, 16'h8000);
		`PEF_CHK("sat_l", 16'h7FFF, ol)
		`PEF_CHK("gen_r", 16'h8001, orr)
		// Biquads rewritten while the effects filter is off.
		for (int i = 0; i < 10; i++) begin
			wr(5'(3 + i), (i == 1 || i == 5) ? 16'h4000 : 16'h0000);
			wr(5'(16 + i), (i == 1) ? 16'h2000 : ((i == 5) ? 16'h4000 : 16'h0000));
		end
		cfg(1'b0, 1'b1, 1'b0);
		settle(16'h1000, 16'h1000);
		`PEF_CHK("bq_l", 16'h0800, ol)
		`PEF_CHK("bq_r", 16'h0400, orr)
		cfg(1'b0, 1'b1, 1'b1);
		settle(16'h1000, 16'h0800);
		`PEF_CHK("td_l", 16'h1300, ol)
		`PEF_CHK("td_r", 16'h0B00, orr)
		// Slowest rate with a new attenuation.
		src_u.gap = 1250;
		three_d_atten_i = 4'hF;
		xfer(16'h1000, 16'h0800);
		xfer(16'h1000, 16'h0800);
		`PEF_CHK("att_l", 16'h15A0, ol)
		`PEF_CHK("att_r", 16'h0DA0, orr)
		// A settled held level near 1.35 and 0.85 of a code step gives codes 1..2 and 0..1.
		`PEF_CHK("dsm_l", 1'b1, (dsm_left_o == 5'h01 || dsm_left_o == 5'h02))
		`PEF_CHK("dsm_r", 1'b1, (dsm_right_o == 5'h00 || dsm_right_o == 5'h01))
		test_done();
	end
endmodule : pef_filter_chain_tb
